// *** trace_port_regs.vh ***
// register map, field positions, reset values and timing counts of the trace port
`ifndef TRACE_PORT_REGS_VH
`define TRACE_PORT_REGS_VH

// ****************************************
// register offsets
// ****************************************
`define TRACE_BYTE_OFFSET     8'h00
`define TRACE_CONTROL_OFFSET  8'h04

// ****************************************
// control fields and reset values
// ****************************************
`define CTRL_EDGE_SEL_BIT     0
`define CTRL_ENABLE_BIT       1
`define CTRL_EDGE_SEL_RESET   1'b0
`define CTRL_ENABLE_RESET     1'b0
`define TRACE_BYTE_RESET      8'h00
`define TRACE_CONTROL_RESET   8'h00

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS         100
`define TRACE_HALF_NS         400
`define TRACE_HALF_CYCLES     8'h04
`define HALF_COUNT_W          5
`define LAST_HALF_RISE        5'h10
`define LAST_HALF_FALL        5'h0f

`endif

// *** trace_fifo.v ***
// synchronous fifo of flip-flops with valid and ready on both sides
module trace_fifo
#(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW    = 4
)
(
	input  wire             clk,
	input  wire             rst,
	input  wire             ce,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      count;
	wire            push;
	wire            pop;

	// honest full and empty from the fill count
	assign in_ready  = (count != DEPTH[AW:0]);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data  = mem[rd_ptr];
	assign push      = ce & in_valid & in_ready;
	assign pop       = ce & out_valid & out_ready;

	// storage entries, written only by index
	always @(posedge clk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	// pointers and fill count
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count  <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
			if (pop)
				rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
			if (push & ~pop)
				count <= count + {{AW{1'b0}}, 1'b1};
			else if (pop & ~push)
				count <= count - {{AW{1'b0}}, 1'b1};
		end
	end

endmodule

// *** serial_trace_byte_port.v ***
// transmit-only serial trace port: register access, byte queue and two-wire shifter
//
// Overview of operation
// - A write to the trace byte register queues one transfer that sends exactly that byte, started once enable is 1.
// - Bits leave least significant first, one byte per transfer, outward only.
// - With edge select 0 data changes on the rising trace clock edge, with 1 on the falling.
// - Each bit stays stable across the opposite edge, where the receiver samples it.
// - Between transfers the trace clock and trace data outputs both sit high.
// - The trace clock and all shifting derive from the bus clock, with no other clock input.
// - Reading the trace byte register returns the last byte written, or 00h after reset.
// - A write to the trace byte register is held off while a byte is still being sent.
// - The enable bit gates the start of each transfer, resets to 0, and is the block enable.
// - While disabled the clock request output is 0 regardless of transfer state.
// - While enabled and transferring the clock request output is 1.
// - The idle condition is internal and no readable bit shows it.
// - The port raises no interrupt.
// - System reset returns both registers to 00h: disabled, rising shift edge.
`include "trace_port_regs.vh"

module serial_trace_byte_port
(
	input  wire       clk,
	input  wire       rst,
	input  wire       ce,
	input  wire       bus_req,
	input  wire       bus_write,
	input  wire [7:0] bus_addr,
	input  wire [7:0] bus_wdata,
	output reg  [7:0] bus_rdata,
	output reg        bus_ack,
	output reg        trace_clk_out,
	output reg        trace_data_out,
	output reg        clk_req
);

	// ****************************************
	// local declarations
	// ****************************************
	localparam ST_IDLE  = 2'b01;
	localparam ST_SHIFT = 2'b10;
	localparam [7:0] HALF_CYCLES = `TRACE_HALF_CYCLES;

	reg  [1:0]               state;
	reg  [7:0]               trace_byte;
	reg                      edge_sel;
	reg                      enable;
	reg  [7:0]               shifter;
	reg  [7:0]               half_timer;
	reg  [`HALF_COUNT_W-1:0] half_index;
	reg                      shift_falling;
	reg                      fifo_push;
	reg  [7:0]               fifo_in;
	reg  [7:0]               next_rdata;
	wire                     fifo_in_ready;
	wire                     fifo_out_valid;
	wire [7:0]               fifo_out_data;
	wire                     fifo_pop;
	wire                     take;
	wire                     hit_byte;
	wire                     hit_ctrl;
	wire                     busy;
	wire                     write_stall;
	wire                     half_done;
	wire                     last_half;
	wire                     frame_done;
	wire [`HALF_COUNT_W-1:0] last_index;
	wire [`HALF_COUNT_W-1:0] next_half_index;
	wire                     shift_here;

	// ****************************************
	// register access
	// ****************************************

	// decode, and hold off byte writes while a byte is queued or on the wire
	assign hit_byte    = (bus_addr == `TRACE_BYTE_OFFSET);
	assign hit_ctrl    = (bus_addr == `TRACE_CONTROL_OFFSET);
	assign busy        = (state == ST_SHIFT) | fifo_out_valid | fifo_push;
	assign write_stall = bus_write & hit_byte & (busy | ~fifo_in_ready);
	assign take        = ce & bus_req & ~bus_ack & ~write_stall;

	// control register: shift edge select and enable
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			edge_sel <= `CTRL_EDGE_SEL_RESET;
			enable   <= `CTRL_ENABLE_RESET;
		end
		else if (ce)
		begin
			if (take & bus_write & hit_ctrl)
			begin
				edge_sel <= bus_wdata[`CTRL_EDGE_SEL_BIT];
				enable   <= bus_wdata[`CTRL_ENABLE_BIT];
			end
		end
	end

	// data register and the push of each accepted byte into the queue
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			trace_byte <= `TRACE_BYTE_RESET;
			fifo_push  <= 1'b0;
			fifo_in    <= `TRACE_BYTE_RESET;
		end
		else if (ce)
		begin
			fifo_push <= 1'b0;
			if (take & bus_write & hit_byte)
			begin
				trace_byte <= bus_wdata;
				fifo_in    <= bus_wdata;
				fifo_push  <= 1'b1;
			end
		end
	end

	// read data chosen by address; unmapped offsets read as zero
	always @*
	begin
		next_rdata = 8'h00;
		if (hit_byte)
			next_rdata = trace_byte;
		else if (hit_ctrl)
			next_rdata = {6'h00, enable, edge_sel};
	end

	// acknowledge pulse and registered read data
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			bus_rdata <= 8'h00;
			bus_ack   <= 1'b0;
		end
		else if (ce)
		begin
			bus_ack <= take;
			if (take & ~bus_write)
				bus_rdata <= next_rdata;
		end
	end

	// ****************************************
	// byte queue
	// ****************************************

	// sixteen entries deep, but the hold-off keeps at most one byte waiting;
	// a byte stays queued while the port is disabled
	// the shifter pulls one byte when idle and enabled
	assign fifo_pop = (state == ST_IDLE) & enable;

	trace_fifo
	#(
		.WIDTH (8),
		.DEPTH (16),
		.AW    (4)
	)
	u_queue
	(
		.clk       (clk),
		.rst       (rst),
		.ce        (ce),
		.in_valid  (fifo_push),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out_data)
	);

	// ****************************************
	// serial shifter
	// ****************************************

	// frame shape, four bus clocks per half period:
	//   edge select 0: 17 halves, the first low with data still high,
	//   each rise presents the next bit, each fall is the sampling edge,
	//   the closing low half gives the last bit its falling edge
	//   edge select 1: 16 halves, each fall presents the next bit,
	//   each rise is the sampling edge
	//   the shift edge is latched when the frame opens
	//   clock and data both return high once the frame closes
	// half periods of the trace clock counted in bus clocks
	assign half_done       = (half_timer == HALF_CYCLES - 8'h01);
	assign last_index      = shift_falling ? `LAST_HALF_FALL : `LAST_HALF_RISE;
	assign last_half       = (half_index == last_index);
	assign frame_done      = half_done & last_half;
	assign next_half_index = half_index + {{(`HALF_COUNT_W-1){1'b0}}, 1'b1};
	// odd halves are high: rising shift edge enters them, falling enters even ones
	assign shift_here      = shift_falling ? ~next_half_index[0] : next_half_index[0];

	// half period timer and index of the current half within the frame
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			half_timer <= 8'h00;
			half_index <= {`HALF_COUNT_W{1'b0}};
		end
		else if (ce)
		begin
			if (state != ST_SHIFT)
			begin
				half_timer <= 8'h00;
				half_index <= {`HALF_COUNT_W{1'b0}};
			end
			else if (~half_done)
				half_timer <= half_timer + 8'h01;
			else
			begin
				half_timer <= 8'h00;
				if (~last_half)
					half_index <= next_half_index;
			end
		end
	end

	// transfer sequencing, clock and data pins
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state          <= ST_IDLE;
			shifter        <= 8'h00;
			shift_falling  <= 1'b0;
			trace_clk_out  <= 1'b1;
			trace_data_out <= 1'b1;
		end
		else if (ce)
		begin
			case (state)
				ST_IDLE:
				begin
					trace_clk_out  <= 1'b1;
					trace_data_out <= 1'b1;
					if (enable & fifo_out_valid)
					begin
						state         <= ST_SHIFT;
						shift_falling <= edge_sel;
						trace_clk_out <= 1'b0; // first falling edge
						if (edge_sel)
						begin
							trace_data_out <= fifo_out_data[0];
							shifter        <= {1'b0, fifo_out_data[7:1]};
						end
						else
							shifter <= fifo_out_data;
					end
				end
				ST_SHIFT:
				begin
					if (frame_done)
					begin
						state          <= ST_IDLE;
						trace_clk_out  <= 1'b1;
						trace_data_out <= 1'b1;
					end
					else if (half_done)
					begin
						trace_clk_out <= next_half_index[0];
						if (shift_here)
						begin
							// held for a full period, across the sampling edge
							trace_data_out <= shifter[0];
							shifter        <= {1'b0, shifter[7:1]};
						end
					end
				end
				default:
				begin
					state          <= ST_IDLE;
					trace_clk_out  <= 1'b1;
					trace_data_out <= 1'b1;
				end
			endcase
		end
	end

	// ****************************************
	// power management
	// ****************************************

	// a queued byte counts as busy, so the request rises before the first edge, or with it when enable arrives after the byte
	// clock request only when enabled and a byte is pending or on the wire
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			clk_req <= 1'b0;
		else if (ce)
			clk_req <= enable & busy;
	end

	// no interrupt output exists on this port
	// a mid-transfer disable is not guarded; the transfer still completes

endmodule

// *** serial_trace_byte_port_chk.sv ***
// assertion checker watching the trace port's pins and register bus
`include "trace_port_regs.vh"
module serial_trace_byte_port_chk
(
	input wire       clk,
	input wire       rst,
	input wire       ce,
	input wire       bus_req,
	input wire       bus_write,
	input wire [7:0] bus_addr,
	input wire [7:0] bus_wdata,
	input wire [7:0] bus_rdata,
	input wire       bus_ack,
	input wire       trace_clk_out,
	input wire       trace_data_out,
	input wire       clk_req
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       prev_tclk;
	logic [3:0] n_falls;
	// falls of the trace clock counted within the current frame
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			prev_tclk <= 1'b1;
			n_falls <= 4'h0;
		end
		else
		begin
			prev_tclk <= trace_clk_out;
			if (!clk_req)
				n_falls <= 4'h0;
			else if (prev_tclk && !trace_clk_out)
				n_falls <= n_falls + 4'h1;
		end
	end
	// ****
	// pin and bus checks
	// ****
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	chk_read_ack_next: assert property (ce && bus_req && !bus_ack && !bus_write |=> bus_ack)
		else $error("read not acknowledged next cycle");
	chk_reserved_zero: assert property (bus_ack && !bus_write &&
		bus_addr == `TRACE_CONTROL_OFFSET |-> bus_rdata[7:2] == 6'h00)
		else $error("reserved control bits not zero");
	chk_half_hold: assert property ($changed(trace_clk_out) &&
		!(trace_clk_out && n_falls == 4'h9) |=> $stable(trace_clk_out) [*3])
		else $error("trace clock half shorter than four cycles");
	chk_low_half: assert property ($fell(trace_clk_out) |=> !trace_clk_out [*3] ##1 trace_clk_out)
		else $error("trace clock low half not four cycles");
	chk_data_on_edge: assert property ($changed(trace_data_out) &&
		!(trace_clk_out && trace_data_out && n_falls == 4'h8) |-> $changed(trace_clk_out))
		else $error("trace data moved between clock edges");
	chk_fall_count: assert property ($fell(trace_clk_out) |-> n_falls < 4'h9)
		else $error("too many trace clock falls in one frame");
	chk_idle_high: assert property (!clk_req && !$past(clk_req) |-> trace_clk_out && trace_data_out)
		else $error("link lines not high while idle");
	chk_fall_req: assert property ($fell(trace_clk_out) |-> clk_req)
		else $error("transfer running without clock request");
	chk_write_held: assert property (bus_req && bus_write &&
		bus_addr == `TRACE_BYTE_OFFSET && !trace_clk_out |-> !bus_ack)
		else $error("data write acknowledged mid transfer");
	chk_reset_idle: assert property ($fell(rst) |-> trace_clk_out && trace_data_out && !clk_req)
		else $error("outputs not idle after reset");
endmodule

// *** trace_capture_model.sv ***
// behavioural capture system at the far end of the two-wire trace link
module trace_capture_model
(
	input  wire        clk,
	input  wire        rst,
	input  wire        edge_sel,
	input  wire        trace_clk_in,
	input  wire        trace_data_in,
	output logic       byte_valid,
	output logic [7:0] byte_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       prev_clk;
	logic       in_frame;
	logic [3:0] n_bits;
	wire        fell_edge = prev_clk && !trace_clk_in;
	wire        sample    = edge_sel ? (!prev_clk && trace_clk_in) : fell_edge;
	// ****
	// edge finder and shift register, bus clock only
	// ****
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			prev_clk <= 1'b1;
			in_frame <= 1'b0;
			n_bits <= 4'h0;
			byte_valid <= 1'b0;
			byte_out <= 8'h00;
		end
		else
		begin
			prev_clk <= trace_clk_in;
			byte_valid <= 1'b0;
			if (fell_edge && !in_frame)
			begin
				in_frame <= 1'b1; // first fall opens a frame, never a sample
				n_bits <= 4'h0;
			end
			if (sample && in_frame)
			begin
				byte_out <= {trace_data_in, byte_out[7:1]}; // first bit lands lowest
				n_bits <= n_bits + 4'h1;
				byte_valid <= (n_bits == 4'h7);
				in_frame <= (n_bits != 4'h7);
			end
		end
	end
endmodule

// *** tb_serial_trace_byte_port.sv ***
// self-checking bench for the serial trace byte port
`include "trace_port_regs.vh"
module tb_serial_trace_byte_port;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk, rst, ce, bus_req, bus_write, bus_ack, sel, cap_valid;
	logic       trace_clk_out, trace_data_out, clk_req;
	logic [7:0] bus_addr, bus_wdata, bus_rdata, cap_byte, last;
	logic [7:0] exp_rd[$];
	logic [7:0] exp_byte[$];
	int         miscompares, n_checks, j, k;
	serial_trace_byte_port DUT (.clk(clk), .rst(rst), .ce(ce), .bus_req(bus_req),
		.bus_write(bus_write), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
		.bus_ack(bus_ack), .trace_clk_out(trace_clk_out), .trace_data_out(trace_data_out),
		.clk_req(clk_req));
	trace_capture_model cap (.clk(clk), .rst(rst), .edge_sel(sel), .trace_clk_in(trace_clk_out),
		.trace_data_in(trace_data_out), .byte_valid(cap_valid), .byte_out(cap_byte));
	// ****
	// clock, tasks and result watcher
	// ****
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task end_sim;
		begin
			$display("checks %0d miscompares %0d", n_checks, miscompares);
			if (miscompares == 0 && n_checks > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	task cmp(input string name, input logic [7:0] e, input logic [7:0] g);
		begin
			n_checks++;
			if (g !== e)
			begin
				miscompares++;
				$display("[ERR] %s expected %h seen %h", name, e, g);
			end
		end
	endtask
	// one request held until the acknowledge is sampled
	task bus_cycle(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int i;
		begin
			@(posedge clk);
			bus_req <= 1'b1;
			bus_write <= wr;
			bus_addr <= a;
			bus_wdata <= d;
			for (i = 0; i < 200; i++)
			begin
				@(posedge clk);
				if (bus_ack === 1'b1)
					break;
			end
			if (i == 200)
			begin
				miscompares++;
				end_sim;
			end
			else
				bus_req <= 1'b0;
		end
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		begin
			exp_rd.push_back(e);
			bus_cycle(1'b0, a, 8'h00);
		end
	endtask
	task send(input logic [7:0] b);
		begin
			exp_byte.push_back(b);
			last = b;
			bus_cycle(1'b1, `TRACE_BYTE_OFFSET, b);
		end
	endtask
	task drain;
		int i;
		begin
			for (i = 0; i < 400 && exp_byte.size() != 0; i++)
				@(posedge clk);
			if (exp_byte.size() != 0)
			begin
				miscompares++;
				end_sim;
			end
			else
				repeat (10) @(posedge clk);
		end
	endtask
	// pops the oldest note whenever a read answer or a captured byte appears
	always @(posedge clk)
	begin
		if (bus_ack === 1'b1 && bus_write === 1'b0)
			cmp("read", exp_rd.size() ? exp_rd.pop_front() : ~bus_rdata, bus_rdata);
		if (cap_valid === 1'b1)
			cmp("byte", exp_byte.size() ? exp_byte.pop_front() : ~cap_byte, cap_byte);
	end
	initial
	begin
		void'($urandom(32'hbbc6));
		{rst, ce, bus_req, bus_write, sel, bus_addr, bus_wdata} = {3'b110, 2'b00, 16'h0000};
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rd(`TRACE_BYTE_OFFSET, `TRACE_BYTE_RESET);
		rd(`TRACE_CONTROL_OFFSET, `TRACE_CONTROL_RESET);
		bus_cycle(1'b1, 8'h08, 8'hff);
		rd(8'h08, 8'h00);
		// clock enable low freezes the bus: no answer until it returns
		ce <= 1'b0;
		fork
			rd(`TRACE_CONTROL_OFFSET, `TRACE_CONTROL_RESET);
			begin
				repeat (6) @(posedge clk);
				cmp("frozen ack", 8'h00, {7'h00, bus_ack});
				ce <= 1'b1;
			end
		join
		send(8'($urandom));
		repeat (40) @(posedge clk);
		cmp("clk_req", 8'h00, {7'h00, clk_req});
		cmp("trace clock", 8'h01, {7'h00, trace_clk_out});
		for (k = 0; k < 2; k++)
		begin
			sel <= k[0];
			bus_cycle(1'b1, `TRACE_CONTROL_OFFSET, k ? 8'hff : 8'h02);
			rd(`TRACE_CONTROL_OFFSET, {6'h00, 1'b1, k[0]});
			for (j = 0; j < 3; j++)
				send(8'($urandom));
			drain;
			cmp("clk_req", 8'h00, {7'h00, clk_req});
			rd(`TRACE_BYTE_OFFSET, last);
		end
		// a second reset after both registers were written
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(`TRACE_BYTE_OFFSET, `TRACE_BYTE_RESET);
		rd(`TRACE_CONTROL_OFFSET, `TRACE_CONTROL_RESET);
		cmp("trace data", 8'h01, {7'h00, trace_data_out});
		end_sim;
	end
endmodule
bind serial_trace_byte_port serial_trace_byte_port_chk chk (.clk(clk), .rst(rst), .ce(ce),
	.bus_req(bus_req), .bus_write(bus_write), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
	.bus_rdata(bus_rdata), .bus_ack(bus_ack), .trace_clk_out(trace_clk_out),
	.trace_data_out(trace_data_out), .clk_req(clk_req));
